/* File: ddrh_ctrl.sv */
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
module ddrh_ctrl (
   // system
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   // apb slave
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // memory clock and command pins
   output logic             ddr_ck,
   output logic             ddr_ck_n,
   output logic             ddr_cke,
   output logic             ddr_cs_n,
   output logic             ddr_ras_n,
   output logic             ddr_cas_n,
   output logic             ddr_we_n,
   output logic      [1:0]  ddr_ba,
   output logic      [12:0] ddr_a,
   output logic             ddr_odt,
   output logic      [3:0]  ddr_dm,
   // data bus
   input  wire logic [31:0] ddr_dq_in,
   output logic      [31:0] ddr_dq_out,
   output logic             ddr_dq_oe,
   // strobes
   input  wire logic [3:0]  ddr_dqs_in,
   output logic      [3:0]  ddr_dqs_out,
   output logic             ddr_dqs_oe,
   output logic      [3:0]  ddr_dqs_n_out,
   output logic             ddr_dqs_n_oe
);

   // software visible state and sequencer state
   logic [31:0]              cfg;
   logic [12:0]              addr;
   ddrh_pkg::ddrh_op_t       op;
   logic [1:0]               bank;
   logic                     ap;
   logic                     go_pend;
   logic                     rd_done;
   logic                     rd_tmo;
   logic [15:0]              wmask;
   logic [31:0]              wdata [ddrh_pkg::BEATS];
   ddrh_pkg::ddrh_state_t    st;
   logic [1:0]               ph;
   logic [2:0]               wl_cnt;
   logic [3:0]               wq;
   logic [7:0]               tmo_cnt;
   // synchronisers for the pins the device drives
   logic [31:0]              dq_s1;
   logic [31:0]              dq_s2;
   logic [3:0]               dqs_s1;
   logic [3:0]               dqs_s2;
   logic [3:0]               dqs_s3;
   logic [3:0]               lane_full;

   // apb decode
   wire        setup    = psel & ~penable & ~pready;
   wire        acc      = psel & penable & pready;
   wire [7:0]  a_sel    = paddr;
   wire        hit_cmd  = a_sel == ddrh_pkg::OFS_CMD;
   wire        hit_addr = a_sel == ddrh_pkg::OFS_ADDR;
   wire        hit_cfg  = a_sel == ddrh_pkg::OFS_CFG;
   wire        hit_stat = a_sel == ddrh_pkg::OFS_STAT;
   wire        hit_wm   = a_sel == ddrh_pkg::OFS_WMASK;
   wire        hit_wd   = a_sel[7:4] == ddrh_pkg::OFS_WDATA[7:4] && a_sel[1:0] == 2'h0;
   wire        hit_rd   = a_sel[7:4] == ddrh_pkg::OFS_RDATA[7:4] && a_sel[1:0] == 2'h0;
   wire        mapped   = hit_cmd | hit_addr | hit_cfg | hit_stat | hit_wm | hit_wd | hit_rd;
   wire        busy     = go_pend | (st != ddrh_pkg::S_IDLE);
   // a new command while one is running would corrupt the pins
   wire        bad      = ~mapped | (pwrite & hit_cmd & busy) | (pwrite & hit_rd);
   wire        wr_ok    = acc & pwrite & ~pslverr;
   wire [1:0]  wi       = a_sel[3:2];

   // read data assembled per lane
   wire [31:0] rd_word;
   wire [31:0] stat_word = {29'h0, rd_tmo, rd_done, busy};
   wire [31:0] next_prdata = hit_cmd  ? {23'h0, ap, 2'h0, bank, 1'h0, op} :
                             hit_addr ? {19'h0, addr} :
                             hit_cfg  ? cfg :
                             hit_stat ? stat_word :
                             hit_wm   ? {16'h0, wmask} :
                             hit_wd   ? wdata[wi] :
                             hit_rd   ? rd_word : 32'h0;

   // quarter phase of ck; commands change on the falling edge
   wire        fall_slot = ph == 2'h1;
   wire [1:0]  next_ph   = ph + 2'h1;
   wire        std_page  = cfg[ddrh_pkg::CFG_STD_PAGE];
   wire [2:0]  wl        = cfg[ddrh_pkg::CFG_WL_LSB +: 3];
   wire        is_rw     = (op == ddrh_pkg::OP_RD) | (op == ddrh_pkg::OP_WR);
   wire        is_rc     = is_rw | (op == ddrh_pkg::OP_ACT);
   wire        is_bank   = is_rc | (op == ddrh_pkg::OP_PRE) | (op == ddrh_pkg::OP_MRS);

   // address pins per command
   wire        a12_val   = (is_rc & std_page) ? 1'b0 : addr[12];
   wire        a10_val   = (is_rw | op == ddrh_pkg::OP_PRE) ? ap : addr[10];
   wire [12:0] next_a    = (op == ddrh_pkg::OP_MRS) ? addr :
                           is_rc ? {a12_val, addr[11], a10_val, addr[9:0]} :
                           (op == ddrh_pkg::OP_PRE) ? {2'h0, ap, 10'h0} : 13'h0;
   wire [1:0]  next_ba   = is_bank ? bank : 2'h0;
   ddrh_pkg::ddrh_cmd_pins_t cmd_pins;
   assign cmd_pins = ddrh_pkg::ddrh_encode(op);

   // write beat selection: even quarters carry data, odd quarters move dqs
   wire [1:0]  beat      = 2'(wq[3:1] - 3'h1);
   wire        beat_q    = ~wq[0] & (wq >= 4'h2) & (wq < ddrh_pkg::WR_LAST_Q);
   wire        dqs_q     = wq[0] & (wq >= 4'h3);
   wire [3:0]  beat_msk  = wmask[4*beat +: 4];
   wire        dm_en     = cfg[ddrh_pkg::CFG_DM_EN];
   wire        rd_all    = &lane_full;
   wire        rd_live   = st == ddrh_pkg::S_READ;

   // apb handshake; no wait state, answer registered
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else begin
         pready  <= setup;
         pslverr <= setup & bad;
         if (setup) begin
            prdata <= next_prdata;
         end
      end
   end

   // register writes
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg   <= ddrh_pkg::CFG_RESET;
         addr  <= 13'h0;
         op    <= ddrh_pkg::OP_NOP;
         bank  <= 2'h0;
         ap    <= 1'b0;
         wmask <= 16'h0;
      end else if (wr_ok) begin
         if (hit_cfg) cfg <= pwdata & ddrh_pkg::CFG_MASK;
         if (hit_addr) addr <= pwdata[12:0];
         if (hit_wm) wmask <= pwdata[15:0];
         if (hit_cmd) begin
            op   <= ddrh_pkg::ddrh_op_t'(pwdata[ddrh_pkg::CMD_OP_LSB +: 3]);
            bank <= pwdata[ddrh_pkg::CMD_BA_LSB +: 2];
            ap   <= pwdata[ddrh_pkg::CMD_AP_BIT];
         end
      end
   end

   // write data words, kept apart so the array needs no reset
   always_ff @(posedge sys_clk) begin
      if (wr_ok & hit_wd) begin
         wdata[wi] <= pwdata;
      end
   end

   // status flags; a finishing read wins over the clear of a new command
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         go_pend <= 1'b0;
         rd_done <= 1'b0;
         rd_tmo  <= 1'b0;
      end else begin
         if (wr_ok & hit_cmd) begin
            go_pend <= 1'b1;
            rd_done <= 1'b0;
            rd_tmo  <= 1'b0;
         end else if (st == ddrh_pkg::S_IDLE && fall_slot) begin
            go_pend <= 1'b0;
         end
         if (rd_live & rd_all) rd_done <= 1'b1;
         if (rd_live & ~rd_all & tmo_cnt == 8'h0) rd_tmo <= 1'b1;
      end
   end

   // ck divider: four sys_clk per ck period, 100 ns
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ph       <= 2'h0;
         ddr_ck   <= 1'b0;
         ddr_ck_n <= 1'b1;
      end else begin
         ph       <= next_ph;
         ddr_ck   <= ~next_ph[1];
         ddr_ck_n <= next_ph[1];
      end
   end

   // static pins follow the configuration
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ddr_cke <= 1'b0;
         ddr_odt <= 1'b0;
      end else begin
         ddr_cke <= cfg[ddrh_pkg::CFG_CKE];
         ddr_odt <= cfg[ddrh_pkg::CFG_ODT];
      end
   end

   // sequencer; pins change on ck fall so the rising crossing sees them steady
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st        <= ddrh_pkg::S_IDLE;
         {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <= ddrh_pkg::PINS_DESEL;
         ddr_ba    <= 2'h0;
         ddr_a     <= 13'h0;
         wl_cnt    <= 3'h0;
         wq        <= 4'h0;
         tmo_cnt   <= 8'h0;
      end else begin
         unique case (st)
            ddrh_pkg::S_IDLE: begin
               if (go_pend & fall_slot) begin
                  {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <= cmd_pins;
                  ddr_ba <= next_ba;
                  ddr_a  <= next_a;
                  st     <= ddrh_pkg::S_CMD;
               end
            end
            ddrh_pkg::S_CMD: begin
               if (fall_slot) begin
                  // deselect between commands: device drops anything with cs high
                  {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <= ddrh_pkg::PINS_DESEL;
                  wq      <= 4'h0;
                  tmo_cnt <= ddrh_pkg::RD_TMO_CYC;
                  wl_cnt  <= 3'(wl - 3'h1);
                  if (op == ddrh_pkg::OP_RD) begin
                     st <= ddrh_pkg::S_READ;
                  end else if (op == ddrh_pkg::OP_WR) begin
                     st <= (wl <= 3'h1) ? ddrh_pkg::S_WRITE : ddrh_pkg::S_WLAT;
                  end else begin
                     st <= ddrh_pkg::S_IDLE;
                  end
               end
            end
            ddrh_pkg::S_WLAT: begin
               if (fall_slot) begin
                  wl_cnt <= 3'(wl_cnt - 3'h1);
                  if (wl_cnt <= 3'h1) st <= ddrh_pkg::S_WRITE;
               end
            end
            ddrh_pkg::S_WRITE: begin
               wq <= 4'(wq + 4'h1);
               if (wq == ddrh_pkg::WR_LAST_Q) st <= ddrh_pkg::S_IDLE;
            end
            ddrh_pkg::S_READ: begin
               tmo_cnt <= 8'(tmo_cnt - 8'h1);
               if (rd_all | tmo_cnt == 8'h0) st <= ddrh_pkg::S_IDLE;
            end
         endcase
      end
   end

   // write data and strobes; strobe edges on ck edges, beats a quarter earlier
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ddr_dq_out    <= 32'h0;
         ddr_dq_oe     <= 1'b0;
         ddr_dm        <= 4'h0;
         ddr_dqs_out   <= 4'h0;
         ddr_dqs_n_out <= 4'hf;
         ddr_dqs_oe    <= 1'b0;
         ddr_dqs_n_oe  <= 1'b0;
      end else if (st == ddrh_pkg::S_WRITE && wq != ddrh_pkg::WR_LAST_Q) begin
         ddr_dq_oe    <= 1'b1;
         ddr_dqs_oe   <= 1'b1;
         // complementary strobes all on or all off together
         ddr_dqs_n_oe <= cfg[ddrh_pkg::CFG_DQSN_EN];
         if (beat_q) begin
            ddr_dq_out <= wdata[beat];
            ddr_dm     <= dm_en ? beat_msk : 4'h0;
         end
         if (dqs_q) begin
            ddr_dqs_out   <= {4{wq[1]}};
            ddr_dqs_n_out <= {4{~wq[1]}};
         end
      end else begin
         ddr_dq_oe     <= 1'b0;
         ddr_dm        <= 4'h0;
         ddr_dqs_out   <= 4'h0;
         ddr_dqs_n_out <= 4'hf;
         ddr_dqs_oe    <= 1'b0;
         ddr_dqs_n_oe  <= 1'b0;
      end
   end

   // pin synchronisers; third strobe stage only feeds edge detection
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         dq_s1  <= 32'h0;
         dq_s2  <= 32'h0;
         dqs_s1 <= 4'h0;
         dqs_s2 <= 4'h0;
         dqs_s3 <= 4'h0;
      end else begin
         dq_s1  <= ddr_dq_in;
         dq_s2  <= dq_s1;
         dqs_s1 <= ddr_dqs_in;
         dqs_s2 <= dqs_s1;
         dqs_s3 <= dqs_s2;
      end
   end

   // read capture per byte lane on each strobe edge, both directions
   for (genvar l = 0; l < 4; l++) begin : g_lane
      logic [2:0] cnt;
      logic [7:0] rb [ddrh_pkg::BEATS];
      // data and strobe share sync delay, so edge-aligned data is already new
      wire        edge_seen = dqs_s2[l] ^ dqs_s3[l];
      assign lane_full[l] = cnt == ddrh_pkg::LANE_BEATS;

      always_ff @(posedge sys_clk or posedge sys_rst) begin
         if (sys_rst) begin
            cnt <= 3'h0;
         end else if (st == ddrh_pkg::S_CMD) begin
            cnt <= 3'h0;
         end else if (rd_live & edge_seen & ~lane_full[l]) begin
            cnt <= 3'(cnt + 3'h1);
         end
      end

      always_ff @(posedge sys_clk) begin
         if (rd_live & edge_seen & ~lane_full[l]) begin
            rb[cnt[1:0]] <= dq_s2[8*l +: 8];
         end
      end
   end

   assign rd_word = {g_lane[3].rb[wi], g_lane[2].rb[wi], g_lane[1].rb[wi], g_lane[0].rb[wi]};

endmodule

/* File: ddrh_ctrl_checker.sv */
`timescale 1ns/1ps
module ddrh_ctrl_checker (
   // system and apb
   input wire logic        sys_clk,
   input wire logic        sys_rst,
   input wire logic [7:0]  paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // memory pins
   input wire logic        ddr_ck,
   input wire logic        ddr_cs_n,
   input wire logic        ddr_ras_n,
   input wire logic        ddr_cas_n,
   input wire logic        ddr_we_n,
   input wire logic [1:0]  ddr_ba,
   input wire logic [12:0] ddr_a,
   input wire logic        ddr_odt,
   input wire logic [31:0] ddr_dq_out,
   input wire logic        ddr_dq_oe,
   input wire logic [3:0]  ddr_dqs_out,
   input wire logic        ddr_dqs_oe,
   input wire logic [3:0]  ddr_dqs_n_out,
   input wire logic        ddr_dqs_n_oe
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   // accepted write to the configuration word
   wire        cfg_wr = psel && penable && pready && pwrite && !pslverr
                        && paddr == ddrh_pkg::OFS_CFG;
   logic [1:0] cfg_sh;

   // bus-side shadow of odt and strobe complement bits
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) cfg_sh <= 2'h0;
      else if (cfg_wr) cfg_sh <= {pwdata[3], pwdata[1]};
   end

   chk_odt_from_cfg: assert property (cfg_wr |=> ##[0:1] ddr_odt == cfg_sh[0])
      else $error("odt pin does not follow configuration");
   chk_cmd_on_fall: assert property (
      $changed({ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n, ddr_ba, ddr_a}) |-> $fell(ddr_ck))
      else $error("command pins moved away from ck fall");
   chk_cmd_one_ck: assert property ($fell(ddr_cs_n) |-> !ddr_cs_n[*4] ##1 ddr_cs_n)
      else $error("command not held one ck period");
   chk_cmd_held: assert property (
      !ddr_cs_n && !$fell(ddr_cs_n) |-> $stable({ddr_ras_n, ddr_cas_n, ddr_we_n, ddr_ba, ddr_a}))
      else $error("command or address changed mid command");
   chk_wr_preamble: assert property (
      $rose(ddr_dq_oe) |-> ddr_dqs_oe && ddr_dqs_out == 4'h0 ##1 ddr_dqs_out == 4'h0
      ##1 ddr_dqs_out == 4'h0 ##1 ddr_dqs_out == 4'hf)
      else $error("write strobe preamble wrong");
   chk_burst_length: assert property (
      $rose(ddr_dqs_oe) |-> ddr_dqs_oe[*8] ##1 ddr_dqs_oe[*2] ##1 !ddr_dqs_oe && !ddr_dq_oe)
      else $error("write burst length wrong");
   chk_strobe_centred: assert property (
      ddr_dqs_oe && $changed(ddr_dqs_out) |-> $stable(ddr_dq_out))
      else $error("write data moved on a strobe edge");
   chk_dqsn_comp: assert property (
      ddr_dqs_n_oe |-> ddr_dqs_oe && ddr_dqs_n_out == ~ddr_dqs_out)
      else $error("complement strobe not inverse");
   chk_dqsn_enable: assert property ($rose(ddr_dqs_oe) |-> ddr_dqs_n_oe == cfg_sh[1])
      else $error("complement strobe enable wrong");
endmodule

bind ddrh_ctrl ddrh_ctrl_checker u_ddrh_ctrl_checker (
   .sys_clk(sys_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .ddr_ck(ddr_ck),
   .ddr_cs_n(ddr_cs_n), .ddr_ras_n(ddr_ras_n), .ddr_cas_n(ddr_cas_n), .ddr_we_n(ddr_we_n),
   .ddr_ba(ddr_ba), .ddr_a(ddr_a), .ddr_odt(ddr_odt), .ddr_dq_out(ddr_dq_out),
   .ddr_dq_oe(ddr_dq_oe), .ddr_dqs_out(ddr_dqs_out), .ddr_dqs_oe(ddr_dqs_oe),
   .ddr_dqs_n_out(ddr_dqs_n_out), .ddr_dqs_n_oe(ddr_dqs_n_oe));

/* File: ddrh_ctrl_test.sv */
`timescale 1ns/1ps
module ddrh_ctrl_test;
   typedef struct packed {
      logic        w;
      logic [7:0]  a;
      logic [31:0] d;
      logic [31:0] x;
      logic        e;
   } ddrh_row_t;

   logic        sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, e;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, r, ddr_dq_in, ddr_dq_out, mem_dq, wd [4], ex [4];
   logic        ddr_ck, ddr_ck_n, ddr_cke, ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n, ddr_odt;
   logic        ddr_dq_oe, ddr_dqs_oe, ddr_dqs_n_oe;
   logic [1:0]  ddr_ba;
   logic [12:0] ddr_a;
   logic [3:0]  ddr_dm, ddr_dqs_in, ddr_dqs_out, ddr_dqs_n_out, mem_dqs;
   int          err_total, num_checks, k;
   ddrh_row_t   rows [7] = '{
      '{1'b0, 8'h08, 32'h0, 32'h0000_0210, 1'b0}, '{1'b1, 8'h08, 32'hffff_ffff, 32'h0, 1'b0},
      '{1'b0, 8'h08, 32'h0, 32'h0000_071f, 1'b0}, '{1'b1, 8'h10, 32'h0000_a5a5, 32'h0, 1'b0},
      '{1'b0, 8'h10, 32'h0, 32'h0000_a5a5, 1'b0}, '{1'b0, 8'h44, 32'h0, 32'h0, 1'b1},
      '{1'b1, 8'h30, 32'h1, 32'h0, 1'b1}};

   // two-way lines resolved from both parties
   assign ddr_dq_in  = ddr_dq_oe ? ddr_dq_out : mem_dq;
   assign ddr_dqs_in = ddr_dqs_oe ? ddr_dqs_out : mem_dqs;

   ddrh_ctrl u_ddrh_ctrl (.sys_clk(sys_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ddr_ck(ddr_ck), .ddr_ck_n(ddr_ck_n), .ddr_cke(ddr_cke),
      .ddr_cs_n(ddr_cs_n), .ddr_ras_n(ddr_ras_n), .ddr_cas_n(ddr_cas_n), .ddr_we_n(ddr_we_n),
      .ddr_ba(ddr_ba), .ddr_a(ddr_a), .ddr_odt(ddr_odt), .ddr_dm(ddr_dm),
      .ddr_dq_in(ddr_dq_in), .ddr_dq_out(ddr_dq_out), .ddr_dq_oe(ddr_dq_oe),
      .ddr_dqs_in(ddr_dqs_in), .ddr_dqs_out(ddr_dqs_out), .ddr_dqs_oe(ddr_dqs_oe),
      .ddr_dqs_n_out(ddr_dqs_n_out), .ddr_dqs_n_oe(ddr_dqs_n_oe));

   ddrh_mem_model u_ddrh_mem_model (.ddr_ck(ddr_ck), .ddr_cs_n(ddr_cs_n),
      .ddr_ras_n(ddr_ras_n), .ddr_cas_n(ddr_cas_n), .ddr_we_n(ddr_we_n), .ddr_ba(ddr_ba),
      .ddr_a(ddr_a), .ddr_odt(ddr_odt), .ddr_dm(ddr_dm), .ddr_dq_out(ddr_dq_out),
      .ddr_dqs_out(ddr_dqs_out), .ddr_dqs_oe(ddr_dqs_oe), .mem_dq(mem_dq), .mem_dqs(mem_dqs));

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   task automatic final_report();
      if (err_total == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      num_checks++;
      if (s !== x) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, s, x);
      end
   endtask

   // one apb transfer; idle cycle after so psel is never set twice at one edge
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
      int n;
      n = 0;
      psel <= 1'b1; pwrite <= w; paddr <= ad; pwdata <= d; penable <= 1'b0;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         err_total++;
         final_report();
      end
      rd = prdata; er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge sys_clk);
   endtask

   // poll status until the command path is free
   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         apb(1'b0, ddrh_pkg::OFS_STAT, 32'h0, r, e);
         n++;
      end while (r[0] !== 1'b0 && n < 200);
      if (n >= 200) begin
         err_total++;
         final_report();
      end
   endtask

   task automatic cmd(input ddrh_pkg::ddrh_op_t op, input logic [1:0] b, input logic ap,
                      input logic [12:0] ad);
      apb(1'b1, ddrh_pkg::OFS_ADDR, {19'h0, ad}, r, e);
      apb(1'b1, ddrh_pkg::OFS_CMD, {23'h0, ap, 2'h0, b, 1'b0, op}, r, e);
      chk(e, 1'b0);
      wait_idle();
   endtask

   initial begin
      sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0; pwdata = 32'h0;
      repeat (20) @(posedge sys_clk);
      chk({ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n, ddr_odt, ddr_dq_oe, ddr_dqs_oe}, 7'h78);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      // register table rows
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d, r, e);
         chk(e, rows[i].e);
         if (!rows[i].w) chk(r, rows[i].x);
      end
      // termination on, then mode register loads and termination disabled
      apb(1'b1, ddrh_pkg::OFS_CFG, 32'h0000_0213, r, e);
      cmd(ddrh_pkg::OP_MRS, 2'h1, 1'b0, 13'h0004);
      chk(u_ddrh_mem_model.emr1, 32'h4);
      repeat (8) @(posedge sys_clk);
      chk({ddr_cke, ddr_ck ^ ddr_ck_n, u_ddrh_mem_model.term_on}, 3'h7);
      cmd(ddrh_pkg::OP_MRS, 2'h0, 1'b0, 13'h1042);
      chk(u_ddrh_mem_model.mr, 32'h1042);
      cmd(ddrh_pkg::OP_MRS, 2'h1, 1'b0, 13'h0000);
      repeat (8) @(posedge sys_clk);
      chk({ddr_odt, u_ddrh_mem_model.term_on}, 2'h2);
      // activate, then a second command while busy is refused
      cmd(ddrh_pkg::OP_ACT, 2'h2, 1'b0, 13'h1abc);
      chk({u_ddrh_mem_model.row_q[2], ddr_a}, {12'habc, 13'h0abc});
      apb(1'b1, ddrh_pkg::OFS_ADDR, 32'h0000_0123, r, e);
      apb(1'b1, ddrh_pkg::OFS_CMD, 32'h0000_0011, r, e);
      apb(1'b1, ddrh_pkg::OFS_CMD, 32'h0000_0001, r, e);
      chk(e, 1'b1);
      wait_idle();
      chk(u_ddrh_mem_model.open_q, 4'h6);
      // plain burst write, every byte stored
      k = {2'h2, 12'habc, 9'h008};
      for (int b = 0; b < 4; b++) begin
         wd[b] = 32'ha0b0_c0d0 + b;
         apb(1'b1, ddrh_pkg::OFS_WDATA + 8'(4 * b), wd[b], r, e);
      end
      apb(1'b1, ddrh_pkg::OFS_WMASK, 32'h0, r, e);
      cmd(ddrh_pkg::OP_WR, 2'h2, 1'b0, 13'h0008);
      for (int b = 0; b < 4; b++) chk(u_ddrh_mem_model.mem[k + b], wd[b]);
      // masked write with complement strobes: one lane kept per beat
      apb(1'b1, ddrh_pkg::OFS_CFG, 32'h0000_021f, r, e);
      cmd(ddrh_pkg::OP_MRS, 2'h1, 1'b0, 13'h0804);
      for (int b = 0; b < 4; b++) begin
         ex[b] = ~wd[b];
         apb(1'b1, ddrh_pkg::OFS_WDATA + 8'(4 * b), ex[b], r, e);
         ex[b][8*b +: 8] = wd[b][8*b +: 8];
      end
      apb(1'b1, ddrh_pkg::OFS_WMASK, 32'h0000_8421, r, e);
      cmd(ddrh_pkg::OP_WR, 2'h2, 1'b0, 13'h0008);
      for (int b = 0; b < 4; b++) chk(u_ddrh_mem_model.mem[k + b], ex[b]);
      // read back the merged burst
      cmd(ddrh_pkg::OP_RD, 2'h2, 1'b0, 13'h0008);
      apb(1'b0, ddrh_pkg::OFS_STAT, 32'h0, r, e);
      chk(r[2:0], 3'h2);
      for (int b = 0; b < 4; b++) begin
         apb(1'b0, ddrh_pkg::OFS_RDATA + 8'(4 * b), 32'h0, r, e);
         chk(r, ex[b]);
      end
      // single bank precharge, then all banks
      cmd(ddrh_pkg::OP_PRE, 2'h2, 1'b0, 13'h0000);
      chk(u_ddrh_mem_model.open_q, 4'h2);
      cmd(ddrh_pkg::OP_PRE, 2'h0, 1'b1, 13'h0000);
      chk(u_ddrh_mem_model.open_q, 4'h0);
      // reset in mid-run: pins deselect at once, configuration back to its reset word
      sys_rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      chk({ddr_cs_n, ddr_cke, ddr_odt, ddr_dq_oe}, 4'h8);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      apb(1'b0, ddrh_pkg::OFS_CFG, 32'h0, r, e);
      chk(r, 32'h0000_0210);
      final_report();
   end
endmodule

/* File: ddrh_mem_model.sv */
`timescale 1ns/1ps
module ddrh_mem_model #(
   parameter int RD_LAT_NS  = 210, // kept off sys_clk edges so pin sampling never races
   parameter int BEAT_NS    = 50,
   parameter int ODT_EN_BIT = 2,
   parameter int DM_EN_BIT  = 11
) (
   // clock and command
   input  wire logic        ddr_ck,
   input  wire logic        ddr_cs_n,
   input  wire logic        ddr_ras_n,
   input  wire logic        ddr_cas_n,
   input  wire logic        ddr_we_n,
   input  wire logic [1:0]  ddr_ba,
   input  wire logic [12:0] ddr_a,
   input  wire logic        ddr_odt,
   // write side from controller
   input  wire logic [3:0]  ddr_dm,
   input  wire logic [31:0] ddr_dq_out,
   input  wire logic [3:0]  ddr_dqs_out,
   input  wire logic        ddr_dqs_oe,
   // read side from device
   output logic      [31:0] mem_dq,
   output logic      [3:0]  mem_dqs
);
   logic [12:0] mr, emr1;
   logic [11:0] row_q [4];
   logic [3:0]  open_q, dqs_prev;
   logic        term_on, wr_act;
   logic [31:0] mem [int];
   int          wkey, wbeat [4];

   initial begin
      {mr, emr1, open_q, dqs_prev, term_on, wr_act, mem_dq, mem_dqs} = '0;
   end

   // a12 dropped: standard page rows are twelve bits
   function automatic int key(logic [1:0] b, logic [12:0] c);
      return {b, row_q[b], c[8:0]};
   endfunction

   // one termination flag stands for dq, strobes and masks alike
   always @(posedge ddr_ck) begin
      term_on = ddr_odt && emr1[ODT_EN_BIT];
      if (!ddr_cs_n) begin
         case ({ddr_ras_n, ddr_cas_n, ddr_we_n})
            3'h3: begin
               row_q[ddr_ba] = ddr_a[11:0];
               open_q[ddr_ba] = 1'b1;
            end
            3'h5: fork rd_burst(key(ddr_ba, ddr_a)); join_none
            3'h4: begin
               wkey = key(ddr_ba, ddr_a);
               wr_act = 1'b1;
               wbeat = '{0, 0, 0, 0};
            end
            3'h2: if (ddr_a[10]) open_q = 4'h0; else open_q[ddr_ba] = 1'b0;
            3'h0: if (ddr_ba == 2'h0) mr = ddr_a; else if (ddr_ba == 2'h1) emr1 = ddr_a;
            default: ;
         endcase
      end
   end

   // beats taken on both strobe edges, lane by lane
   always @(ddr_dqs_out) begin
      for (int l = 0; l < 4; l++)
         if (ddr_dqs_oe && wr_act && ddr_dqs_out[l] !== dqs_prev[l] && wbeat[l] < 4) begin
            if (!(ddr_dm[l] && emr1[DM_EN_BIT]))
               mem[wkey + wbeat[l]][8*l +: 8] = ddr_dq_out[8*l +: 8];
            wbeat[l]++;
         end
      dqs_prev = ddr_dqs_out;
   end

   // edge aligned read; strobe parks low, data inverted once released
   task automatic rd_burst(input int k);
      #(RD_LAT_NS);
      mem_dqs = 4'h0;
      #(BEAT_NS);
      for (int b = 0; b < 4; b++) begin
         mem_dq = mem[k + b];
         mem_dqs = ~mem_dqs;
         #(BEAT_NS);
      end
      mem_dq = ~mem_dq;
   endtask
endmodule

/* File: ddrh_pkg.sv */
package ddrh_pkg;

   // register offsets, byte addresses on the apb side
   localparam logic [7:0] OFS_CMD   = 8'h00;
   localparam logic [7:0] OFS_ADDR  = 8'h04;
   localparam logic [7:0] OFS_CFG   = 8'h08;
   localparam logic [7:0] OFS_STAT  = 8'h0c;
   localparam logic [7:0] OFS_WMASK = 8'h10;
   localparam logic [7:0] OFS_WDATA = 8'h20;
   localparam logic [7:0] OFS_RDATA = 8'h30;

   // command register fields
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_BA_LSB = 4;
   localparam int CMD_AP_BIT = 8;

   // configuration register fields
   localparam int CFG_CKE      = 0;
   localparam int CFG_ODT      = 1;
   localparam int CFG_DM_EN    = 2;
   localparam int CFG_DQSN_EN  = 3;
   localparam int CFG_STD_PAGE = 4;
   localparam int CFG_WL_LSB   = 8;
   localparam logic [31:0] CFG_MASK  = 32'h0000_071f;
   localparam logic [31:0] CFG_RESET = 32'h0000_0210;

   // status register fields
   localparam int STAT_BUSY    = 0;
   localparam int STAT_RD_DONE = 1;
   localparam int STAT_RD_TMO  = 2;

   // burst of four beats, two per ck period
   localparam int          BEATS       = 4;
   localparam logic [2:0]  LANE_BEATS  = 3'h4;
   localparam logic [3:0]  WR_LAST_Q   = 4'ha;
   // read wait limit in sys_clk cycles
   localparam int          RD_TMO_NS   = 3200;
   localparam int          CLK_PERIOD_NS = 25;
   localparam logic [7:0]  RD_TMO_CYC  = 8'(RD_TMO_NS / CLK_PERIOD_NS);

   typedef enum logic [2:0] {
      OP_NOP = 3'h0,
      OP_ACT = 3'h1,
      OP_RD  = 3'h2,
      OP_WR  = 3'h3,
      OP_PRE = 3'h4,
      OP_MRS = 3'h5,
      OP_REF = 3'h6
   } ddrh_op_t;

   typedef enum logic [4:0] {
      S_IDLE  = 5'b00001,
      S_CMD   = 5'b00010,
      S_WLAT  = 5'b00100,
      S_WRITE = 5'b01000,
      S_READ  = 5'b10000
   } ddrh_state_t;

   // command pins, all active low
   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
   } ddrh_cmd_pins_t;

   localparam ddrh_cmd_pins_t PINS_DESEL = 4'hf;

   function automatic ddrh_cmd_pins_t ddrh_encode(input ddrh_op_t op);
      ddrh_cmd_pins_t p;
      p = 4'h7;
      case (op)
         OP_ACT:  p = 4'h3;
         OP_RD:   p = 4'h5;
         OP_WR:   p = 4'h4;
         OP_PRE:  p = 4'h2;
         OP_MRS:  p = 4'h0;
         OP_REF:  p = 4'h1;
         default: p = 4'h7;
      endcase
      return p;
   endfunction

endpackage
